// >>> logic/cif_frontend.sv
// Counting-input front end: pin filters, encoder decode, aux inputs, outputs, APB registers
// Notes on behaviour
// - Zero mark counts only in quadrature-with-mark mode, else ignored.
// - Plain pulse mode counts A edges, direction from a software bit.
// - Pulse-direction mode counts A edges, B level picks direction.
// - Up/down mode counts up on A, down on B.
// - Enabled encoder filter drops changes shorter than the minimum time.
// - Minimum time assumes duty between forty and sixty percent.
// - Eleven encoder filter steps, 100 Hz to 200 kHz, default 200 kHz.
// - Three aux inputs serve gate, synchronisation and capture.
// - Aux levels are always readable by software.
// - Aux filter off or 0.05 to 20 ms, default 0.1 ms.
// - Two outputs follow comparison results or software values.
// - Push-pull wire breaks on encoder inputs are detected and reported.
// - Missing supply and encoder supply fault are flagged.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cif_frontend #(
  parameter int unsigned ENC_CYC0 = cif_pkg::ENC_CYC_100HZ,
  parameter int unsigned ENC_CYC1 = cif_pkg::ENC_CYC_200HZ,
  parameter int unsigned ENC_CYC2 = cif_pkg::ENC_CYC_500HZ,
  parameter int unsigned ENC_CYC3 = cif_pkg::ENC_CYC_1KHZ,
  parameter int unsigned ENC_CYC4 = cif_pkg::ENC_CYC_2KHZ,
  parameter int unsigned AUX_CYC3 = cif_pkg::AUX_CYC_400US,
  parameter int unsigned AUX_CYC4 = cif_pkg::AUX_CYC_800US,
  parameter int unsigned AUX_CYC5 = cif_pkg::AUX_CYC_1600US,
  parameter int unsigned AUX_CYC6 = cif_pkg::AUX_CYC_3200US,
  parameter int unsigned AUX_CYC7 = cif_pkg::AUX_CYC_12800US,
  parameter int unsigned AUX_CYC8 = cif_pkg::AUX_CYC_20MS
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cif_pkg::ADDR_W-1:0] PADDR,
  input wire logic [cif_pkg::DATA_W-1:0] PWDATA,
  output logic [cif_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ENC_A,
  input wire logic ENC_B,
  input wire logic ENC_N,
  input wire logic [2:0] ENC_LINE_SENSE,
  input wire logic AUX_INPUT_ZERO,
  input wire logic AUX_INPUT_ONE,
  input wire logic AUX_INPUT_TWO,
  input wire logic MAIN_SUPPLY_OK,
  input wire logic ENCODER_SUPPLY_OUTPUT_FAULT,
  input wire logic [1:0] CMP_MATCH,
  output logic COUNT_UP,
  output logic COUNT_DOWN,
  output logic ZERO_MARK,
  output logic GATE_LEVEL,
  output logic SYNC_PULSE,
  output logic CAPTURE_PULSE,
  output logic COMPARE_OUTPUT_ZERO,
  output logic COMPARE_OUTPUT_ONE,
  output logic IRQ
);
  import cif_pkg::*;

  localparam int unsigned ENC_SLOW [ENC_N_SLOW] = '{ENC_CYC0, ENC_CYC1, ENC_CYC2, ENC_CYC3, ENC_CYC4};
  localparam int unsigned AUX_SLOW [AUX_STEPS-AUX_FIRST_SLOW] = '{AUX_CYC3, AUX_CYC4, AUX_CYC5, AUX_CYC6,
                                                                  AUX_CYC7, AUX_CYC8};
  localparam logic [CNT_W-1:0] WIRE_LAST = CNT_W'(WIRE_BREAK_CYC - 1);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic [CFG_W-1:0] cfg_q;
  logic [EV_W-1:0] ev_q, ev_en_q, ev_set, ev_clr, ev_d;
  logic [2:0] enc_f, aux_f, enc_prev_q, aux_prev_q, wire_mask;
  logic [1:0] out_q;
  logic [SEL_W-1:0] enc_idx, aux_idx;
  logic [CNT_W-1:0] enc_tab [ENC_STEPS];
  logic [CNT_W-1:0] aux_tab [AUX_STEPS];
  logic [CNT_W-1:0] enc_limit, aux_limit, wire_cnt_q;
  logic [DATA_W-1:0] rdata_d, status;
  logic err_d, pready_q, acc, wr, wire_low, wire_fault_q;
  logic a_rise, b_rise, n_rise, a_chg, b_chg, up_d, dn_d, zero_d;
  cif_mode_e mode;

  // Two flip-flops on every encoder, aux, sense and supply pin before use
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
    end else begin
      sync1_q <= {ENCODER_SUPPLY_OUTPUT_FAULT, MAIN_SUPPLY_OK, ENC_LINE_SENSE, AUX_INPUT_TWO, AUX_INPUT_ONE,
                  AUX_INPUT_ZERO, ENC_N, ENC_B, ENC_A};
      sync2_q <= sync1_q;
    end
  end

  // Configuration fields
  assign mode = cif_mode_e'(cfg_q[CFG_MODE_LSB +: MODE_W]);
  assign enc_idx = (cfg_q[CFG_ENC_SEL_LSB +: SEL_W] > ENC_SEL_MAX) ? ENC_SEL_MAX
                 : cfg_q[CFG_ENC_SEL_LSB +: SEL_W];
  assign aux_idx = (cfg_q[CFG_AUX_SEL_LSB +: SEL_W] > AUX_SEL_MAX) ? AUX_SEL_MAX
                 : cfg_q[CFG_AUX_SEL_LSB +: SEL_W];

  // limits from the 40 percent duty floor
  for (genvar i = 0; i < ENC_STEPS; i++) begin : g_enc_tab
    if (i < ENC_N_SLOW) begin : g_slow
      assign enc_tab[i] = CNT_W'(ENC_SLOW[i]);
    end else begin : g_fast
      assign enc_tab[i] = CNT_W'(cyc_ceil(min_pulse_ns(ENC_FREQ_HZ[i])));
    end
  end

  for (genvar i = 0; i < AUX_STEPS; i++) begin : g_aux_tab
    if (i < AUX_FIRST_SLOW) begin : g_fast
      assign aux_tab[i] = CNT_W'(cyc_ceil(AUX_TIME_NS[i]));
    end else begin : g_slow
      assign aux_tab[i] = CNT_W'(AUX_SLOW[i-AUX_FIRST_SLOW]);
    end
  end
  assign enc_limit = enc_tab[enc_idx];
  assign aux_limit = aux_tab[aux_idx];

  a_enc_default_time: assert property (
    enc_idx == ENC_SEL_MAX |-> enc_limit == CNT_W'(2_000 / CLK_PERIOD_NS))
    else $error("200 kHz step is not 2.0 us");
  a_aux_default_time: assert property (
    aux_idx == AUX_SEL_DEF |-> aux_limit == CNT_W'(100_000 / CLK_PERIOD_NS))
    else $error("Default aux filter is not 0.1 ms");

  cif_glitch_filter #(.WIDTH(3), .CW(CNT_W)) u_enc_filt (
    .clk(CLK),
    .reset_n(RESET_N),
    .enable(cfg_q[CFG_ENC_FILT_EN]),
    .limit(enc_limit),
    .raw(sync2_q[SY_ENC_LSB +: 3]),
    .clean(enc_f)
  );

  cif_glitch_filter #(.WIDTH(3), .CW(CNT_W)) u_aux_filt (
    .clk(CLK),
    .reset_n(RESET_N),
    .enable(aux_idx != AUX_SEL_OFF),
    .limit(aux_limit),
    .raw(sync2_q[SY_AUX_LSB +: 3]),
    .clean(aux_f)
  );

  // Previous filtered levels for edge detection
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      enc_prev_q <= '0;
      aux_prev_q <= '0;
    end else begin
      enc_prev_q <= enc_f;
      aux_prev_q <= aux_f;
    end
  end
  assign a_rise = enc_f[0] && !enc_prev_q[0];
  assign b_rise = enc_f[1] && !enc_prev_q[1];
  assign n_rise = enc_f[2] && !enc_prev_q[2];
  assign a_chg = enc_f[0] ^ enc_prev_q[0];
  assign b_chg = enc_f[1] ^ enc_prev_q[1];

  // Encoder type decode into count strobes
  always_comb begin
    up_d = 1'b0;
    dn_d = 1'b0;
    zero_d = 1'b0;
    case (mode)
      M_QUAD_N, M_QUAD: begin
        // both tracks evaluated, double steps dropped
        if (a_chg ^ b_chg) begin
          up_d = enc_f[0] ^ enc_prev_q[1];
          dn_d = enc_f[1] ^ enc_prev_q[0];
        end
        // zero mark only with mark option
        zero_d = (mode == M_QUAD_N) && n_rise;
      end
      M_PULSE: begin
        up_d = a_rise && !cfg_q[CFG_SW_DOWN];
        dn_d = a_rise && cfg_q[CFG_SW_DOWN];
      end
      M_PULSE_DIR: begin
        up_d = a_rise && !enc_f[1];
        dn_d = a_rise && enc_f[1];
      end
      M_UP_DOWN: begin
        up_d = a_rise && !b_rise;
        dn_d = b_rise && !a_rise;
      end
      default: begin
        up_d = 1'b0;
      end
    endcase
  end

  // Registered count strobes
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      COUNT_UP <= 1'b0;
      COUNT_DOWN <= 1'b0;
      ZERO_MARK <= 1'b0;
    end else begin
      COUNT_UP <= up_d;
      COUNT_DOWN <= dn_d;
      ZERO_MARK <= zero_d;
    end
  end

  a_zero_gated: assert property (
    ZERO_MARK |-> $past(mode) == M_QUAD_N)
    else $error("Zero mark outside zero-mark mode");
  a_pulse_swdir: assert property (
    mode == M_PULSE && a_rise |=> COUNT_UP != $past(cfg_q[CFG_SW_DOWN]) && COUNT_DOWN == $past(cfg_q[CFG_SW_DOWN]))
    else $error("Pulse mode ignored software direction");
  a_pulse_bdir: assert property (
    mode == M_PULSE_DIR && a_rise |=> COUNT_DOWN == $past(enc_f[1]) && !ZERO_MARK)
    else $error("Pulse-direction mode ignored B level");
  a_updown_down: assert property (
    mode == M_UP_DOWN && b_rise && !a_rise |=> COUNT_DOWN && !COUNT_UP)
    else $error("Up/down mode missed a down pulse");
  a_quad_lead: assert property (
    (mode == M_QUAD || mode == M_QUAD_N) && $rose(enc_f[0]) && !enc_f[1] && $stable(enc_f[1])
    |=> COUNT_UP && !COUNT_DOWN)
    else $error("Quadrature A lead did not count up");

  // gate, sync and capture roles of the aux inputs
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      GATE_LEVEL <= 1'b0;
      SYNC_PULSE <= 1'b0;
      CAPTURE_PULSE <= 1'b0;
    end else begin
      GATE_LEVEL <= cfg_q[CFG_GATE_EN] && aux_f[0];
      SYNC_PULSE <= cfg_q[CFG_SYNC_EN] && aux_f[1] && !aux_prev_q[1];
      CAPTURE_PULSE <= cfg_q[CFG_CAPT_EN] && aux_f[2] && !aux_prev_q[2];
    end
  end

  a_capture_once: assert property (
    cfg_q[CFG_CAPT_EN] && $rose(aux_f[2]) |=> CAPTURE_PULSE ##1 !CAPTURE_PULSE)
    else $error("Capture pulse missing or too long");

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        out_q[i] <= cfg_q[CFG_OUT_AUTO_LSB+i] ? CMP_MATCH[i] : cfg_q[CFG_OUT_SW_LSB+i];
      end
    end
  end
  assign COMPARE_OUTPUT_ZERO = out_q[0];
  assign COMPARE_OUTPUT_ONE = out_q[1];

  a_cmp_auto: assert property (
    cfg_q[CFG_OUT_AUTO_LSB] && CMP_MATCH[0] |=> COMPARE_OUTPUT_ZERO)
    else $error("Output zero missed its comparison");
  a_cmp_soft: assert property (
    !cfg_q[CFG_OUT_AUTO_LSB+1] |=> COMPARE_OUTPUT_ONE == $past(cfg_q[CFG_OUT_SW_LSB+1]))
    else $error("Output one ignored software value");

  // watch only the lines the encoder type uses
  assign wire_mask = {mode == M_QUAD_N, mode != M_PULSE, 1'b1} & {3{cfg_q[CFG_WIRE_EN]}};
  assign wire_low = |(wire_mask & ~sync2_q[SY_SENSE_LSB +: 3]);

  // break declared after a steady loss of line drive
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wire_cnt_q <= '0;
      wire_fault_q <= 1'b0;
    end else begin
      wire_fault_q <= wire_low && (wire_cnt_q == WIRE_LAST);
      if (!wire_low) begin
        wire_cnt_q <= '0;
      end else if (wire_cnt_q != WIRE_LAST) begin
        wire_cnt_q <= wire_cnt_q + 1'b1;
      end
    end
  end

  a_wire_break: assert property (
    wire_low && wire_cnt_q == WIRE_LAST |=> wire_fault_q ##1 ev_q[EV_WIRE])
    else $error("Wire break not flagged");

  // Sticky events, set wins over clear
  always_comb begin
    ev_set = '0;
    ev_set[EV_WIRE] = wire_fault_q;
    ev_set[EV_SUPPLY] = !sync2_q[SY_SUP_OK];
    ev_set[EV_ENC_SUP] = sync2_q[SY_SUP_FLT];
    ev_set[EV_ZERO] = zero_d;
    ev_clr = (wr && PADDR == REG_EV_CLEAR) ? PWDATA[EV_W-1:0] : '0;
    ev_d = (ev_q & ~ev_clr) | ev_set;
  end

  // Event and interrupt registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ev_q <= '0;
      IRQ <= 1'b0;
    end else begin
      ev_q <= ev_d;
      IRQ <= |(ev_d & ev_en_q);
    end
  end

  a_supply_flag: assert property (
    !sync2_q[SY_SUP_OK] |=> ev_q[EV_SUPPLY] && (IRQ == |(ev_q & $past(ev_en_q))))
    else $error("Missing supply not flagged");

  // Live status word
  always_comb begin
    status = '0;
    status[ST_ENC_LSB +: 3] = enc_f;
    status[ST_AUX_LSB +: 3] = aux_f;
    status[ST_OUT_LSB +: 2] = out_q;
    status[ST_WIRE] = wire_fault_q;
    status[ST_SUPPLY] = !sync2_q[SY_SUP_OK];
    status[ST_ENC_SUP] = sync2_q[SY_SUP_FLT];
  end

  // APB: one wait state, commit on the ready edge
  assign acc = PSEL && PENABLE && !pready_q;
  assign wr = PSEL && PENABLE && pready_q && PWRITE;

  // Read data and error decode
  always_comb begin
    rdata_d = '0;
    err_d = 1'b0;
    case (PADDR)
      REG_CONFIG: rdata_d[CFG_W-1:0] = cfg_q;
      REG_STATUS: rdata_d = status;
      REG_EVENT: rdata_d[EV_W-1:0] = ev_q;
      REG_EV_CLEAR: rdata_d = '0;
      REG_EV_ENABLE: rdata_d[EV_W-1:0] = ev_en_q;
      default: err_d = 1'b1;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pready_q <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else begin
      pready_q <= acc;
      PSLVERR <= acc && err_d;
      if (acc && !PWRITE) begin
        PRDATA <= rdata_d;
      end
    end
  end
  assign PREADY = pready_q;

  // Writable registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_q <= CFG_RST;
      ev_en_q <= '0;
    end else if (wr) begin
      if (PADDR == REG_CONFIG) begin
        cfg_q <= PWDATA[CFG_W-1:0];
      end
      if (PADDR == REG_EV_ENABLE) begin
        ev_en_q <= PWDATA[EV_W-1:0];
      end
    end
  end

  a_aux_report: assert property (
    acc && !PWRITE && PADDR == REG_STATUS |=> PREADY && PRDATA[ST_AUX_LSB +: 3] == $past(aux_f))
    else $error("Status read lost aux levels");
endmodule : cif_frontend
`default_nettype wire

// >>> logic/cif_pkg.sv
// Shared constants and types for the counting-input front end
package cif_pkg;
  // Clock rate and derived period
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned NS_PER_S = 1_000_000_000;
  localparam int unsigned CLK_PERIOD_NS = NS_PER_S / CLK_HZ;
  // Least pulse share of a period the filter tolerates
  localparam int unsigned DUTY_MIN_PCT = 40;
  localparam int unsigned PCT_FULL = 100;
  // Filter choices
  localparam int unsigned ENC_STEPS = 11;
  localparam int unsigned ENC_FREQ_HZ [ENC_STEPS] = '{100, 200, 500, 1_000, 2_000, 5_000, 10_000, 20_000,
                                                     50_000, 100_000, 200_000};
  localparam int unsigned AUX_STEPS = 9;
  localparam int unsigned AUX_TIME_NS [AUX_STEPS] = '{0, 50_000, 100_000, 400_000, 800_000, 1_600_000,
                                                     3_200_000, 12_800_000, 20_000_000};
  localparam int unsigned WIRE_BREAK_NS = 100_000;

  // Least pulse or pause time of a filter frequency
  function automatic int unsigned min_pulse_ns(input int unsigned freq_hz);
    return (NS_PER_S / PCT_FULL * DUTY_MIN_PCT) / freq_hz;
  endfunction : min_pulse_ns

  // Time to clock cycles, rounded up, at least one
  function automatic int unsigned cyc_ceil(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction : cyc_ceil

  // Long counts, all but WIRE_BREAK_CYC overridable at the top
  localparam int unsigned ENC_CYC_100HZ = cyc_ceil(min_pulse_ns(ENC_FREQ_HZ[0]));
  localparam int unsigned ENC_CYC_200HZ = cyc_ceil(min_pulse_ns(ENC_FREQ_HZ[1]));
  localparam int unsigned ENC_CYC_500HZ = cyc_ceil(min_pulse_ns(ENC_FREQ_HZ[2]));
  localparam int unsigned ENC_CYC_1KHZ = cyc_ceil(min_pulse_ns(ENC_FREQ_HZ[3]));
  localparam int unsigned ENC_CYC_2KHZ = cyc_ceil(min_pulse_ns(ENC_FREQ_HZ[4]));
  localparam int unsigned AUX_CYC_400US = cyc_ceil(AUX_TIME_NS[3]);
  localparam int unsigned AUX_CYC_800US = cyc_ceil(AUX_TIME_NS[4]);
  localparam int unsigned AUX_CYC_1600US = cyc_ceil(AUX_TIME_NS[5]);
  localparam int unsigned AUX_CYC_3200US = cyc_ceil(AUX_TIME_NS[6]);
  localparam int unsigned AUX_CYC_12800US = cyc_ceil(AUX_TIME_NS[7]);
  localparam int unsigned AUX_CYC_20MS = cyc_ceil(AUX_TIME_NS[8]);
  localparam int unsigned WIRE_BREAK_CYC = cyc_ceil(WIRE_BREAK_NS);
  localparam int unsigned ENC_N_SLOW = 5;
  localparam int unsigned AUX_FIRST_SLOW = 3;
  localparam int unsigned CNT_W = 20;

  // Selector fields
  localparam int unsigned SEL_W = 4;
  localparam logic [SEL_W-1:0] ENC_SEL_MAX = 4'hA;
  localparam logic [SEL_W-1:0] AUX_SEL_MAX = 4'h8;
  localparam logic [SEL_W-1:0] AUX_SEL_OFF = 4'h0;
  localparam logic [SEL_W-1:0] AUX_SEL_DEF = 4'h2;
  localparam int unsigned MODE_W = 3;

  // Config register layout
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_ENC_FILT_EN = 3;
  localparam int unsigned CFG_ENC_SEL_LSB = 4;
  localparam int unsigned CFG_AUX_SEL_LSB = 8;
  localparam int unsigned CFG_SW_DOWN = 12;
  localparam int unsigned CFG_OUT_AUTO_LSB = 13;
  localparam int unsigned CFG_OUT_SW_LSB = 15;
  localparam int unsigned CFG_GATE_EN = 17;
  localparam int unsigned CFG_SYNC_EN = 18;
  localparam int unsigned CFG_CAPT_EN = 19;
  localparam int unsigned CFG_WIRE_EN = 20;
  localparam int unsigned CFG_W = 21;
  localparam logic [CFG_W-1:0] CFG_RST = 21'h0_02A8;

  // Event and status layouts
  localparam int unsigned EV_WIRE = 0;
  localparam int unsigned EV_SUPPLY = 1;
  localparam int unsigned EV_ENC_SUP = 2;
  localparam int unsigned EV_ZERO = 3;
  localparam int unsigned EV_W = 4;
  localparam int unsigned ST_ENC_LSB = 0;
  localparam int unsigned ST_AUX_LSB = 3;
  localparam int unsigned ST_OUT_LSB = 6;
  localparam int unsigned ST_WIRE = 8;
  localparam int unsigned ST_SUPPLY = 9;
  localparam int unsigned ST_ENC_SUP = 10;

  // Synchroniser vector layout
  localparam int unsigned SY_ENC_LSB = 0;
  localparam int unsigned SY_AUX_LSB = 3;
  localparam int unsigned SY_SENSE_LSB = 6;
  localparam int unsigned SY_SUP_OK = 9;
  localparam int unsigned SY_SUP_FLT = 10;
  localparam int unsigned SYNC_W = 11;
  localparam logic [SYNC_W-1:0] SYNC_RST = 11'h200;

  // APB map
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_EVENT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_EV_CLEAR = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_EV_ENABLE = 8'h10;

  // Encoder types
  typedef enum logic [MODE_W-1:0] {M_QUAD_N, M_QUAD, M_PULSE_DIR, M_PULSE, M_UP_DOWN} cif_mode_e;
endpackage : cif_pkg

// >>> logic/cif_glitch_filter.sv
// Per-bit glitch filter with a run-time length
`timescale 1ns/1ps
`default_nettype none
module cif_glitch_filter #(
  parameter int unsigned WIDTH = 3,
  parameter int unsigned CW = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [CW-1:0] limit,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  logic [CW-1:0] cnt_q [WIDTH];

  // Output follows a level only after it held limit cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < WIDTH; i++) begin
        cnt_q[i] <= '0;
      end
      clean <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (!enable) begin
          clean[i] <= raw[i];
          cnt_q[i] <= '0;
        end else if (raw[i] == clean[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_q[i] + 1'b1 >= limit) begin
          clean[i] <= raw[i];
          cnt_q[i] <= '0;
        end else begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end

  a_filter_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    enable && raw[0] != clean[0] && cnt_q[0] + 1'b1 < limit |=> clean[0] == $past(clean[0]))
    else $error("Filter passed a change shorter than its limit");
endmodule : cif_glitch_filter
`default_nettype wire

// >>> testbench/cif_enc_model.sv
// Behavioural encoder and pulse sensor driving tracks A, B and N
`timescale 1ns/1ps
`default_nettype none
module cif_enc_model (
  input wire logic clk,
  output logic a,
  output logic b,
  output logic n
);
  // Lines idle low from time zero
  initial begin
    a = 1'b0;
    b = 1'b0;
    n = 1'b0;
  end
  // Idle cycles
  task automatic hold(input int c);
    repeat (c) @(posedge clk);
  endtask : hold
  // Set one line (0 A, 1 B, 2 N) just after an edge, then hold it
  task automatic drive(input int sel, input logic v, input int c);
    @(posedge clk);
    if (sel == 0) a <= v;
    else if (sel == 1) b <= v;
    else n <= v;
    hold(c);
  endtask : drive
  // One pulse and pause of equal length
  task automatic pulse(input int sel, input int c);
    drive(sel, 1'b1, c);
    drive(sel, 1'b0, c);
  endtask : pulse
  task automatic quad(input logic dn, input int steps);
    repeat (steps) drive((a ^ b ^ dn) ? 1 : 0, ~((a ^ b ^ dn) ? b : a), 100);
  endtask : quad
endmodule : cif_enc_model
`default_nettype wire

// >>> testbench/cif_frontend_test.sv
// Self-checking bench for the counting-input front end
`timescale 1ns/1ps
`default_nettype none
module cif_frontend_test;
  import cif_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, sup = 1'b1, sflt = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, lfsr = 32'h91c9_ffd8;
  logic [2:0] aux = 3'h0, sense = 3'h7;
  logic [1:0] cmp = 2'h0;
  logic pready, pslverr, cu, cd, zm, gate, o0, o1, irq, sp, cp;
  wire logic a, b, n;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  logic [2:0] cnt_q[$];
  logic [32:0] rd_q[$];
  logic [1:0] aux_q[$];
  cif_enc_model cif_enc_model_inst (.clk(clk), .a(a), .b(b), .n(n));
  cif_frontend cif_frontend_inst (
    .CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ENC_A(a), .ENC_B(b), .ENC_N(n),
    .ENC_LINE_SENSE(sense), .AUX_INPUT_ZERO(aux[0]), .AUX_INPUT_ONE(aux[1]), .AUX_INPUT_TWO(aux[2]),
    .MAIN_SUPPLY_OK(sup), .ENCODER_SUPPLY_OUTPUT_FAULT(sflt), .CMP_MATCH(cmp), .COUNT_UP(cu),
    .COUNT_DOWN(cd), .ZERO_MARK(zm), .GATE_LEVEL(gate), .SYNC_PULSE(sp), .CAPTURE_PULSE(cp),
    .COMPARE_OUTPUT_ZERO(o0), .COMPARE_OUTPUT_ONE(o1), .IRQ(irq));
  // Clock at 40 MHz
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  // Config word: given type, encoder filter on at 200 kHz, aux filter off
  function automatic logic [31:0] cf(input logic [2:0] m);
    return 32'h0000_00A8 | m;
  endfunction : cf
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask : wt
  // APB transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] ad, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, ad, 32'h0000_0000);
  endtask : rd
  task automatic pushn(input logic [2:0] e, input int k);
    repeat (k) cnt_q.push_back(e);
  endtask : pushn
  // Read data and count strobes against the oldest notes
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr) chk({pslverr, prdata}, rd_q.pop_front());
    if ((cu | cd | zm) === 1'b1) chk({zm, cd, cu}, cnt_q.size() ? cnt_q.pop_front() : 3'h0);
    if ((sp | cp) === 1'b1) chk({cp, sp}, aux_q.size() ? aux_q.pop_front() : 2'h0);
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    int k;
    wt(8);
    rst_n <= 1'b1;
    rd(REG_CONFIG, {1'b0, 11'h0, CFG_RST});
    rd(8'h20, 33'h1_0000_0000);
    apb(1'b1, REG_CONFIG, cf(0));
    pushn(3'b001, 4);
    cif_enc_model_inst.quad(1'b0, 4);
    pushn(3'b010, 4);
    cif_enc_model_inst.quad(1'b1, 4);
    cnt_q.push_back(3'b100);
    cif_enc_model_inst.pulse(2, 150);
    apb(1'b1, REG_CONFIG, cf(1));
    cif_enc_model_inst.pulse(2, 100);
    apb(1'b1, REG_CONFIG, cf(3) | 32'h0000_1000);
    pushn(3'b010, 1);
    cif_enc_model_inst.pulse(0, 100);
    cif_enc_model_inst.pulse(0, 20);
    cif_enc_model_inst.pulse(1, 100);
    apb(1'b1, REG_CONFIG, cf(2));
    pushn(3'b001, 1);
    cif_enc_model_inst.pulse(0, 100);
    cif_enc_model_inst.drive(1, 1'b1, 100);
    pushn(3'b010, 1);
    cif_enc_model_inst.pulse(0, 100);
    cif_enc_model_inst.drive(1, 1'b0, 100);
    apb(1'b1, REG_CONFIG, cf(4));
    k = int'(rnd() % 4) + 1;
    pushn(3'b001, k);
    repeat (k) cif_enc_model_inst.pulse(0, 100);
    pushn(3'b010, 1);
    cif_enc_model_inst.pulse(1, 100);
    // Gate, sync and capture roles all enabled
    apb(1'b1, REG_CONFIG, cf(1) | 32'h000E_0000);
    aux_q.push_back(2'b10);
    aux <= 3'b101;
    wt(10);
    chk(gate, 1'b1);
    rd(REG_STATUS, 33'h0_0000_0028);
    aux_q.push_back(2'b01);
    aux <= 3'b111;
    wt(10);
    apb(1'b1, REG_CONFIG, cf(1) | 32'h0001_2000);
    repeat (4) begin
      cmp <= 2'(rnd());
      wt(4);
      chk({o1, o0}, {1'b1, cmp[0]});
    end
    apb(1'b1, REG_EV_ENABLE, 32'h0000_0002);
    sflt <= 1'b1;
    wt(10);
    chk(irq, 1'b0);
    sup <= 1'b0;
    wt(10);
    chk(irq, 1'b1);
    rd(REG_EVENT, 33'h0_0000_000E);
    sup <= 1'b1;
    sflt <= 1'b0;
    wt(5);
    apb(1'b1, REG_EV_CLEAR, 32'h0000_000F);
    wt(5);
    chk(irq, 1'b0);
    apb(1'b1, REG_CONFIG, cf(1) | 32'h0010_0000);
    sense <= 3'b110;
    wt(4100);
    rd(REG_EVENT, 33'h0_0000_0001);
    sense <= 3'b111;
    wt(200);
    chk(cnt_q.size() + rd_q.size() + aux_q.size(), 0);
    final_report();
  end
endmodule : cif_frontend_test
`default_nettype wire
